// [hdl/dpm_host.sv]
// Purpose: Host-side controller driving one port of the dual-port mailbox RAM
// Assumes: Single clock; device pins asynchronous, inputs synchronised
// Notes: One request at a time; busy and irq inputs only observed

`timescale 1ns/1ps

module dpm_host #(
    parameter bit IS_LEFT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire dpm_pkg::dpm_req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_token_won,
    output logic rsp_blocked,
    output logic mbox_irq,
    output dpm_pkg::dpm_pins_s pins,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    input wire logic [15:0] dq_in,
    input wire logic mailbox_irq_n,
    input wire logic busy_n
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [15:0] dq_s1_q, dq_s2_q;
    logic irq_s1_q, irq_s2_q, busy_s1_q, busy_s2_q;
    // Busy reaches this port as one line: in a depth-expanded array it is
    // the AND of every part's indication, and a width-expanded array has a
    // single master driving it. In slave mode the board ties it high; a low
    // level only blocks writes, so it is observed here and never acted on.

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_s1_q <= dpm_pkg::DATA_RST;
            dq_s2_q <= dpm_pkg::DATA_RST;
            // Idle-high reset values avoid a false flag or busy after reset
            irq_s1_q <= 1'b1;
            irq_s2_q <= 1'b1;
            busy_s1_q <= 1'b1;
            busy_s2_q <= 1'b1;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            irq_s1_q <= mailbox_irq_n;
            irq_s2_q <= irq_s1_q;
            busy_s1_q <= busy_n;
            busy_s2_q <= busy_s1_q;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Fixed access length: the far side never stretches a cycle, so
    // no ready input is needed and a hung device cannot stall the sequencer
    typedef enum logic [1:0] {
        DPM_IDLE,
        DPM_SETUP,
        DPM_STROBE,
        DPM_DONE
    } dpm_state_e;

    dpm_state_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    dpm_pkg::dpm_req_s cur_q;
    logic busy_seen_q;

    wire is_sem = (cur_q.op == dpm_pkg::DPM_OP_SEM_RD) || (cur_q.op == dpm_pkg::DPM_OP_SEM_WR);
    wire is_wr = (cur_q.op == dpm_pkg::DPM_OP_RAM_WR) || (cur_q.op == dpm_pkg::DPM_OP_SEM_WR);
    wire active = (state_q == DPM_SETUP) || (state_q == DPM_STROBE);
    wire take = (state_q == DPM_IDLE) && req_valid;
    wire cnt_end = (cnt_q == 4'h0);
    // Token space uses only the low index bits
    wire [15:0] pin_addr = is_sem ? {13'h0000, cur_q.addr[2:0]} : cur_q.addr;
    // Only bit 0 counts on a token write; drive the rest high for clarity
    wire [15:0] wr_data = is_sem ? {15'h7FFF, cur_q.wdata[0]} : cur_q.wdata;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            DPM_IDLE: begin
                if (req_valid) begin
                    state_d = DPM_SETUP;
                    cnt_d = 4'(dpm_pkg::SETUP_CYC - 1);
                end
            end
            DPM_SETUP: begin
                // Address and enables settle before the strobe
                if (cnt_end) begin
                    state_d = DPM_STROBE;
                    cnt_d = 4'(dpm_pkg::ACCESS_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            DPM_STROBE: begin
                if (cnt_end) begin
                    state_d = DPM_DONE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            DPM_DONE: begin
                state_d = DPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= DPM_IDLE;
            cnt_q <= dpm_pkg::CNT_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_q <= '{op: dpm_pkg::DPM_OP_RAM_RD, addr: dpm_pkg::ADDR_RST,
                       wdata: dpm_pkg::DATA_RST};
        end else if (take) begin
            cur_q <= req;
        end
    end

    // ************************************************************
    // Pin drive, all registered
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Idle port: both enables high puts it in standby
            pins <= '{ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, token_space_select_n: 1'b1,
                      addr: dpm_pkg::ADDR_RST};
            dq_out <= dpm_pkg::DATA_RST;
            dq_oe_n <= 1'b1;
        end else begin
            // Write strobe opens one cycle after the enables and closes one cycle
            // before them, so address and busy are settled around it
            pins.addr <= pin_addr;
            // Token access keeps RAM enable high
            pins.ce_n <= !(active && !is_sem);
            pins.token_space_select_n <= !(active && is_sem);
            pins.rw_n <= !((state_d == DPM_STROBE) && is_wr);
            // Read strobe held through the access so the token latch stays stable
            pins.oe_n <= !(active && !is_wr);
            dq_out <= wr_data;
            dq_oe_n <= !(active && is_wr);
        end
    end

    // ************************************************************
    // Response
    // ************************************************************
    // Blocked accesses are reported, not retried: retry policy is the caller's
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_seen_q <= 1'b0;
        end else if (take) begin
            busy_seen_q <= 1'b0;
        end else if (state_q == DPM_STROBE && !busy_s2_q) begin
            // Write from the busy side never lands
            busy_seen_q <= 1'b1;
        end
    end

    // Result fields hold until the next response; rsp_valid marks a fresh one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= dpm_pkg::DATA_RST;
            rsp_token_won <= 1'b0;
            rsp_blocked <= 1'b0;
            mbox_irq <= 1'b0;
        end else begin
            req_ready <= (state_d == DPM_IDLE);
            rsp_valid <= (state_q == DPM_DONE);
            if (state_q == DPM_DONE) begin
                rsp_rdata <= dq_s2_q;
                // Flag reads 0 on the holding side
                rsp_token_won <= is_sem && !is_wr && !dq_s2_q[0];
                rsp_blocked <= busy_seen_q;
            end
            // Mailbox flag from the far side's write
            mbox_irq <= !irq_s2_q;
        end
    end

endmodule : dpm_host

// [hdl/dpm_pkg.sv]
// Purpose: Shared constants and carrier types for the dual-port mailbox host controller
// Assumes: One port of the dual-port RAM is driven by this controller
// Notes: Pin levels follow the device: enables and strobes are active low

package dpm_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SEM_IDX_W = 3;

    // ************************************************************
    // Mailbox addresses
    // ************************************************************
    localparam logic [15:0] MBOX_LEFT_ADDR = 16'hFFFE;
    localparam logic [15:0] MBOX_RIGHT_ADDR = 16'hFFFF;

    // ************************************************************
    // Timing at 125 MHz
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned ACCESS_NS = 20;
    localparam int unsigned SETUP_NS = 10;
    localparam int unsigned ACCESS_CYC =
        (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC =
        (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [3:0] CNT_RST = 4'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        DPM_OP_RAM_RD,
        DPM_OP_RAM_WR,
        DPM_OP_SEM_RD,
        DPM_OP_SEM_WR
    } dpm_op_e;

    typedef struct packed {
        dpm_op_e op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dpm_req_s;

    typedef struct packed {
        logic ce_n;
        logic rw_n;
        logic oe_n;
        logic token_space_select_n;
        logic [15:0] addr;
    } dpm_pins_s;

endpackage : dpm_pkg

// [dv/dpm_host_monitor.sv]
// Purpose: Port-level checks on the dual-port mailbox host controller
// Assumes: Single clock domain, async active-high reset
// Notes: Pins follow a take by two edges, once the request is registered
`timescale 1ns/1ps
module dpm_host_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire dpm_pkg::dpm_req_s req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic mbox_irq,
    input wire dpm_pkg::dpm_pins_s pins,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic mailbox_irq_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire taken = req_valid && req_ready;
    chk_sem_ce_excl: assert property (!pins.token_space_select_n |-> pins.ce_n)
        else $error("token select with chip enable");
    chk_idle_standby: assert property (req_ready |-> pins.ce_n && pins.token_space_select_n)
        else $error("idle port not in standby");
    chk_rsp_latency: assert property (taken |=> !rsp_valid [*6] ##1 rsp_valid ##1 !rsp_valid)
        else $error("response pulse out of place");
    chk_sem_write: assert property (taken && req.op == dpm_pkg::DPM_OP_SEM_WR |-> ##2
        pins.ce_n && dq_out[0] == $past(req.wdata[0], 2)
        && pins.addr[2:0] == $past(req.addr[2:0], 2)) else $error("token write bits wrong");
    chk_ram_addr: assert property (taken && req.op[1] == 1'b0 |-> ##2 !pins.ce_n
        && pins.addr == $past(req.addr, 2)) else $error("ram address wrong");
    chk_rd_oe: assert property (taken && req.op == dpm_pkg::DPM_OP_RAM_RD
        |-> ##2 (!pins.oe_n && pins.rw_n && dq_oe_n) [*5]) else $error("read strobes wrong");
    chk_strobe_setup: assert property ($fell(pins.rw_n) |-> !$past(pins.ce_n)
        || !$past(pins.token_space_select_n)) else $error("strobe before enable");
    chk_wr_drive: assert property (!pins.rw_n |-> !dq_oe_n && pins.oe_n)
        else $error("write without data drive");
    chk_irq_set: assert property (!mailbox_irq_n [*5] |-> mbox_irq)
        else $error("mailbox flag not reported");
    chk_irq_clear: assert property (mailbox_irq_n [*5] |-> !mbox_irq)
        else $error("mailbox flag stuck");
endmodule : dpm_host_monitor

// [dv/dpm_dev_model.sv]
// Purpose: Behavioural dual-port device seen from the left port
// Assumes: Right port is driven by bench task calls
// Notes: Released data lines show the inverse of the last read value
`timescale 1ns/1ps
module dpm_dev_model (
    input wire logic rst,
    input wire dpm_pkg::dpm_pins_s pins,
    input wire logic [15:0] dq_w,
    input wire logic dq_oe_n,
    output logic [15:0] dq_r,
    output logic irq_n,
    output logic busy_n
);
    logic [15:0] mem [0:65535];
    logic [1:0] own [8];
    logic rq [2][8];
    logic irq_l, irq_r, r_ce;
    logic [15:0] r_addr, sv, lv;
    wire [2:0] ix = pins.addr[2:0];
    wire rd = !pins.oe_n && pins.rw_n && !(pins.ce_n && pins.token_space_select_n);
    wire s_rd = !pins.token_space_select_n && !pins.oe_n;
    // Right side parked first always wins, so left never gets both low
    assign busy_n = !(r_ce && !pins.ce_n && pins.addr == r_addr);
    assign irq_n = !irq_l;
    assign dq_r = rd ? (pins.token_space_select_n ? mem[pins.addr] : sv) : ~lv;
    always @(*) if (rd) lv = dq_r;
    always @(posedge s_rd) sv = {16{own[pins.addr[2:0]] != 2'd1}};
    always @(*) if (!pins.ce_n && !pins.oe_n && pins.addr == 16'hfffe) irq_l = 1'b0;
    always @(posedge rst) begin
        irq_l = 1'b0;
        irq_r = 1'b0;
        r_ce = 1'b0;
        for (int i = 0; i < 8; i++) begin
            own[i] = 2'd0;
            rq[0][i] = 1'b0;
            rq[1][i] = 1'b0;
        end
    end
    // Tokens never gate the array
    always @(posedge pins.rw_n) begin
        if (!pins.ce_n && busy_n && !dq_oe_n) begin
            mem[pins.addr] = dq_w;
            if (pins.addr == 16'hffff) irq_r = 1'b1;
        end else if (!pins.token_space_select_n) sem_w(2'd1, 2'd2, ix, dq_w[0]);
    end
    task automatic sem_w(input logic [1:0] me, input logic [1:0] ot, input logic [2:0] i,
        input logic v);
        if (!v) begin
            rq[me - 1][i] = 1'b1;
            if (own[i] == 2'd0) own[i] = me;
        end else begin
            rq[me - 1][i] = 1'b0;
            if (own[i] == me) own[i] = rq[ot - 1][i] ? ot : 2'd0;
        end
    endtask : sem_w
    task automatic r_wr(input logic [15:0] a, input logic [15:0] d);
        mem[a] = d;
        if (a == 16'hfffe) irq_l = 1'b1;
    endtask : r_wr
    function automatic logic r_flag(input logic [2:0] i);
        return own[i] != 2'd2;
    endfunction : r_flag
endmodule : dpm_dev_model

// [dv/tb.sv]
// Purpose: Self-checking bench for the mailbox host controller
// Assumes: Device model answers on the left port
// Notes: Expected results queue in order of request
`timescale 1ns/1ps
module tb;
    logic clk = 0, rst = 0, req_valid = 0;
    dpm_pkg::dpm_req_s req = '0;
    logic req_ready, rsp_valid, rsp_token_won, rsp_blocked, mbox_irq, dq_oe_n, irq_n, busy_n;
    logic [15:0] rsp_rdata, dq_out, dq_in, a, d, t;
    logic [19:0] e;
    logic [19:0] expq [$];
    logic [39:0] tbl = 40'h91ea_5f27_9f;
    logic [3:0] s;
    logic [2:0] ix;
    dpm_pkg::dpm_pins_s pins;
    int fail_count = 0, samples_checked = 0;
`define CMP(x, y) begin samples_checked++; if ((x) !== (y)) begin fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, x, y); end end
    always #4 clk = ~clk;
    dpm_host u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_token_won(rsp_token_won), .rsp_blocked(rsp_blocked), .mbox_irq(mbox_irq),
        .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
        .mailbox_irq_n(irq_n), .busy_n(busy_n));
    dpm_dev_model u_dev (.rst(rst), .pins(pins), .dq_w(dq_out), .dq_oe_n(dq_oe_n),
        .dq_r(dq_in), .irq_n(irq_n), .busy_n(busy_n));
    always @(negedge clk) if (rsp_valid === 1'b1) begin
        if (expq.size() == 0) `CMP(1'b1, 1'b0)
        else begin
            e = expq.pop_front();
            `CMP(rsp_blocked, e[17])
            if (e[19]) `CMP(rsp_rdata, e[15:0])
            if (e[18]) `CMP(rsp_token_won, e[16])
        end
    end
    task automatic op(input dpm_pkg::dpm_op_e o, input logic [15:0] ad, input logic [15:0] w,
        input logic [19:0] x);
        int n;
        n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
        if (n >= 50) fail_count++;
        req_valid = 1'b1;
        req = '{o, ad, w};
        expq.push_back(x);
        @(negedge clk);
        req_valid = 1'b0;
    endtask : op
    task automatic drain();
        int n;
        n = 0;
        while (expq.size() != 0 && n < 100) begin @(negedge clk); n++; end
        if (n >= 100) fail_count++;
        @(negedge clk);
    endtask : drain
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin #100000; fail_count++; final_report(); end
    initial begin
        void'($urandom(32'h6c4e6790));
        #1 rst = 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            a = (i == 4) ? 16'hffff : $urandom() & 16'hfff0;
            d = $urandom();
            op(dpm_pkg::DPM_OP_RAM_WR, a, d, 20'h0_0000);
            op(dpm_pkg::DPM_OP_RAM_RD, a, 16'h0000, {4'h8, d});
        end
        drain();
        `CMP(u_dev.irq_r, 1'b1)
        $display("test ram done");
        d = $urandom();
        u_dev.r_wr(16'hfffe, d);
        repeat (6) @(negedge clk);
        `CMP(mbox_irq, 1'b1)
        op(dpm_pkg::DPM_OP_RAM_RD, 16'hfffe, 16'h0000, {4'h8, d});
        drain();
        repeat (6) @(negedge clk);
        `CMP(mbox_irq, 1'b0)
        $display("test mailbox done");
        ix = 3'($urandom());
        for (int k = 0; k < 10; k++) begin
            s = tbl[39 - 4 * k -: 4];
            t = $urandom();
            a = {t[15:3], ix};
            if (s[3]) op(dpm_pkg::DPM_OP_SEM_WR, a, {t[15:1], s[2]}, 20'h0_0000);
            else u_dev.sem_w(2'd2, 2'd1, ix, s[2]);
            op(dpm_pkg::DPM_OP_SEM_RD, a, 16'h0000, {3'b110, ~s[1], {16{s[1]}}});
            drain();
            `CMP(u_dev.r_flag(ix), s[0])
        end
        $display("test token done");
        a = $urandom() & 16'h7fff;
        d = $urandom();
        op(dpm_pkg::DPM_OP_RAM_WR, a, d, 20'h0_0000);
        drain();
        u_dev.r_addr = a;
        u_dev.r_ce = 1'b1;
        op(dpm_pkg::DPM_OP_RAM_WR, a, ~d, 20'h2_0000);
        op(dpm_pkg::DPM_OP_RAM_RD, a, 16'h0000, {4'ha, d});
        drain();
        u_dev.r_ce = 1'b0;
        op(dpm_pkg::DPM_OP_RAM_RD, a, 16'h0000, {4'h8, d});
        drain();
        $display("test collision done");
        final_report();
    end
endmodule : tb
bind dpm_host dpm_host_monitor u_mon (.clk, .rst, .req_valid, .req, .req_ready, .rsp_valid,
    .mbox_irq, .pins, .dq_out, .dq_oe_n, .mailbox_irq_n);
